//--- logic/psq_host.sv
/*
 Sequencer that runs the enable-then-disable flow on one subsystem.
 Assumes the device acks every access.
*/
`include "psq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module psq_host #(
    parameter int unsigned timeout_cyc = `PSQ_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic start,
    psq_if.host bus,
    output logic busy,
    output logic done,
    output logic timed_out
);
    typedef enum logic [3:0] {
        PSQ_IDLE = 4'h0, PSQ_WAKE = 4'h1, PSQ_CLKON = 4'h3, PSQ_RSTOFF = 4'h2,
        PSQ_POLL = 4'h6, PSQ_AUTO = 4'h7, PSQ_PRD = 4'h5, PSQ_PWR = 4'h4,
        PSQ_GATE = 4'hc, PSQ_RSTON = 4'hd, PSQ_DONE = 4'hf
    } psq_state_e;

    // ==========================================================
    // Sequence
    psq_state_e st_q, st_d;
    logic pend_q, pend_d;
    logic done_q, done_d;
    logic to_q, to_d;
    logic [31:0] tmr_q, tmr_d;
    psq_pkg::psq_data_t pwr_q, pwr_d;

    always_comb
    begin
        st_d = st_q;
        pend_d = pend_q;
        done_d = done_q;
        to_d = to_q;
        tmr_d = tmr_q;
        pwr_d = pwr_q;
        bus.wr_en = 1'b0;
        bus.rd_en = 1'b0;
        bus.addr = `PSQ_REG_CLKDOM;
        bus.wdata = 32'h0000_0000;
        unique case (st_q)
            PSQ_IDLE: bus.addr = `PSQ_REG_CLKDOM;
            PSQ_WAKE: begin bus.addr = `PSQ_REG_CLKDOM; bus.wdata = `PSQ_CLKDOM_WAKEUP; end
            PSQ_CLKON: begin bus.addr = `PSQ_REG_MODCLK; bus.wdata = `PSQ_MODCLK_ENABLE; end
            PSQ_RSTOFF: begin bus.addr = `PSQ_REG_RESET; bus.wdata = `PSQ_RESET_RELEASE; end
            PSQ_POLL: bus.addr = `PSQ_REG_MODCLK;
            PSQ_AUTO: begin bus.addr = `PSQ_REG_CLKDOM; bus.wdata = `PSQ_CLKDOM_HWAUTO; end
            PSQ_PRD: bus.addr = `PSQ_REG_PWRST;
            PSQ_PWR: begin bus.addr = `PSQ_REG_PWRST; bus.wdata = pwr_q; end
            PSQ_GATE: begin bus.addr = `PSQ_REG_MODCLK; bus.wdata = `PSQ_MODCLK_GATE; end
            PSQ_RSTON: begin bus.addr = `PSQ_REG_RESET; bus.wdata = `PSQ_RESET_ASSERT; end
            PSQ_DONE: bus.addr = `PSQ_REG_CLKDOM;
        endcase
        if (st_q != PSQ_IDLE && st_q != PSQ_DONE && !pend_q)
        begin
            // One access at a time, next waits for ack
            bus.wr_en = (st_q != PSQ_POLL) && (st_q != PSQ_PRD);
            bus.rd_en = (st_q == PSQ_POLL) || (st_q == PSQ_PRD);
            pend_d = 1'b1;
        end
        if (st_q == PSQ_POLL)
            tmr_d = tmr_q + 32'h1;
        if (st_q == PSQ_IDLE && start)
        begin
            st_d = PSQ_WAKE;
            done_d = 1'b0;
            to_d = 1'b0;
            tmr_d = 32'h0;
        end
        else if (pend_q && bus.ack)
        begin
            pend_d = 1'b0;
            unique case (st_q)
                PSQ_WAKE: st_d = PSQ_CLKON;
                PSQ_CLKON: st_d = PSQ_RSTOFF;
                PSQ_RSTOFF: st_d = PSQ_POLL;
                PSQ_POLL:
                begin
                    if ((bus.rdata & `PSQ_IDLEST_MASK) == 32'h0)
                        st_d = PSQ_AUTO;
                    else if (tmr_q >= timeout_cyc)
                    begin
                        to_d = 1'b1;
                        st_d = PSQ_AUTO;
                    end
                end
                PSQ_AUTO: st_d = PSQ_PRD;
                PSQ_PRD:
                begin
                    pwr_d = bus.rdata & `PSQ_PWRST_OFF_MASK;
                    st_d = PSQ_PWR;
                end
                PSQ_PWR: st_d = PSQ_GATE;
                PSQ_GATE: st_d = PSQ_RSTON;
                PSQ_RSTON: st_d = PSQ_DONE;
                default: st_d = st_q;
            endcase
        end
        else if (st_q == PSQ_DONE)
        begin
            done_d = 1'b1;
            st_d = PSQ_IDLE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q <= PSQ_IDLE;
            pend_q <= 1'b0;
            done_q <= 1'b0;
            to_q <= 1'b0;
            tmr_q <= 32'h0;
            pwr_q <= 32'h0;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
            pend_q <= pend_d;
            done_q <= done_d;
            to_q <= to_d;
            tmr_q <= tmr_d;
            pwr_q <= pwr_d;
        end
    end

    assign busy = (st_q != PSQ_IDLE);
    assign done = done_q;
    assign timed_out = to_q;
endmodule : psq_host
`default_nettype wire

//--- logic/psq_consts.svh
/*
 Constants for the priority flag init sequence: register indices, values, timing.
 Assumes a 125 MHz clock.
*/
`ifndef PSQ_CONSTS_SVH
`define PSQ_CONSTS_SVH
`define PSQ_REG_CLKDOM 2'h0
`define PSQ_REG_MODCLK 2'h1
`define PSQ_REG_RESET 2'h2
`define PSQ_REG_PWRST 2'h3
`define PSQ_CLKDOM_WAKEUP 32'h0000_0002
`define PSQ_CLKDOM_HWAUTO 32'h0000_0003
`define PSQ_MODCLK_ENABLE 32'h0000_0001
`define PSQ_MODCLK_GATE 32'h0000_0000
`define PSQ_RESET_RELEASE 32'h0000_0001
`define PSQ_RESET_ASSERT 32'h0000_0003
`define PSQ_IDLEST_MASK 32'h0003_0000
`define PSQ_PWRST_OFF_MASK 32'h0fff_fff0
`define PSQ_PWRST_RESET 32'h0000_0003
`define PSQ_TIMEOUT_MS 100
`define PSQ_CLK_MHZ 125
`define PSQ_TIMEOUT_CYC (`PSQ_TIMEOUT_MS * 1000 * `PSQ_CLK_MHZ)
`define PSQ_FUNC_DELAY 4
`endif

//--- logic/psq_pkg.sv
/*
 Types shared by both ends of the priority flag init sequence.
 Assumes nothing beyond the constants header.
*/
package psq_pkg;
    typedef logic [1:0] psq_addr_t;
    typedef logic [31:0] psq_data_t;
endpackage : psq_pkg

//--- logic/psq_if.sv
/*
 Control link between the sequencer (host) and the subsystem (device).
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface psq_if;
    logic wr_en;
    logic rd_en;
    psq_pkg::psq_addr_t addr;
    psq_pkg::psq_data_t wdata;
    psq_pkg::psq_data_t rdata;
    logic ack;
    modport host (output wr_en, output rd_en, output addr, output wdata, input rdata, input ack);
    modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata, output ack);
endinterface : psq_if
`default_nettype wire

//--- logic/psq_dev.sv
/*
 Signal processor subsystem model: control registers and priority flag.
 Assumes the sequencer issues one access at a time and waits for ack.
*/
`include "psq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Flag undefined until powered and clocked
// - Flag may power up low or high
// - Flag low after enable, stays low
// - Flag feeds interconnect arbitration
// - Host forces wakeup, then enables clock
// - Host then releases subsystem reset
// - Host polls idle bits, 100ms timeout
// - Poll completes before the timeout
// - Host returns clock domain to automatic
// - Host masks power state to off
// - Host gates clock, then asserts reset
// - Sequence runs for every instance
module psq_dev #(
    parameter logic arbitration_priority_flag_init = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    psq_if.dev bus,
    output logic arbitration_priority_flag,
    output logic functional
);
    // ==========================================================
    // State
    psq_pkg::psq_data_t clkdom_q, clkdom_d;
    psq_pkg::psq_data_t modclk_q, modclk_d;
    psq_pkg::psq_data_t rst_q, rst_d;
    psq_pkg::psq_data_t pwr_q, pwr_d;
    psq_pkg::psq_data_t rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic flag_q, flag_d;
    logic inited_q, inited_d;
    logic [2:0] cnt_q, cnt_d;
    logic running;

    // ==========================================================
    // Next state
    always_comb
    begin
        clkdom_d = clkdom_q;
        modclk_d = modclk_q;
        rst_d = rst_q;
        pwr_d = pwr_q;
        rdata_d = rdata_q;
        ack_d = 1'b0;
        flag_d = flag_q;
        inited_d = inited_q;
        cnt_d = cnt_q;
        running = (modclk_q == `PSQ_MODCLK_ENABLE) && (rst_q == `PSQ_RESET_RELEASE);
        // Module becomes functional a few cycles after clock and reset release
        if (!running)
            cnt_d = 3'h0;
        else if (cnt_q != 3'(`PSQ_FUNC_DELAY))
            cnt_d = cnt_q + 3'h1;
        if (running && cnt_q == 3'(`PSQ_FUNC_DELAY))
        begin
            inited_d = 1'b1;
            flag_d = 1'b0;
        end
        if (bus.wr_en)
        begin
            ack_d = 1'b1;
            unique case (bus.addr)
                `PSQ_REG_CLKDOM: clkdom_d = bus.wdata;
                `PSQ_REG_MODCLK: modclk_d = bus.wdata;
                `PSQ_REG_RESET: rst_d = bus.wdata;
                `PSQ_REG_PWRST: pwr_d = bus.wdata;
            endcase
        end
        else if (bus.rd_en)
        begin
            ack_d = 1'b1;
            unique case (bus.addr)
                `PSQ_REG_CLKDOM: rdata_d = clkdom_q;
                `PSQ_REG_MODCLK: rdata_d = modclk_q | ((running && inited_q)
                    ? 32'h0000_0000 : `PSQ_IDLEST_MASK);
                `PSQ_REG_RESET: rdata_d = rst_q;
                `PSQ_REG_PWRST: rdata_d = pwr_q;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            clkdom_q <= 32'h0000_0000;
            modclk_q <= `PSQ_MODCLK_GATE;
            rst_q <= `PSQ_RESET_ASSERT;
            pwr_q <= `PSQ_PWRST_RESET;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            inited_q <= 1'b0;
            cnt_q <= 3'h0;
        end
        else if (clk_en)
        begin
            clkdom_q <= clkdom_d;
            modclk_q <= modclk_d;
            rst_q <= rst_d;
            pwr_q <= pwr_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            inited_q <= inited_d;
            cnt_q <= cnt_d;
        end
    end

    // Reset loads the flag with its power-up level, arbitration_priority_flag_init
    // Once cleared it stays low through any later reset
    logic ever_q = 1'b0;
    always_ff @(posedge clk)
    begin
        if (clk_en && inited_q)
            ever_q <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst && !inited_q && !ever_q)
            flag_q <= arbitration_priority_flag_init;
        else if (sys_rst)
            flag_q <= 1'b0;
        else if (clk_en)
            flag_q <= flag_d;
    end

    assign bus.ack = ack_q;
    assign bus.rdata = rdata_q;
    assign arbitration_priority_flag = flag_q;
    assign functional = inited_q;
endmodule : psq_dev
`default_nettype wire

//--- sim/psq_link_sva.sv
/* Checker on the control link between sequencer and subsystem.
 Assumes one clock and the sync high reset of both ends. */
`include "psq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module psq_link_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire psq_pkg::psq_addr_t addr,
    input wire psq_pkg::psq_data_t wdata,
    input wire psq_pkg::psq_data_t rdata,
    input wire logic ack
);
    // ========
    // Step tracking
    logic [2:0] step_q, step_d;
    logic rd_pend_q, rd_pend_d, idle_ok_q, idle_ok_d;
    psq_pkg::psq_data_t rd_val_q, rd_val_d;
    always_comb
    begin
        step_d = step_q;
        rd_pend_d = rd_en;
        rd_val_d = rd_val_q;
        idle_ok_d = idle_ok_q;
        if (wr_en)
        begin
            step_d = (step_q == 3'h6) ? 3'h0 : step_q + 3'h1;
            idle_ok_d = 1'b0;
        end
        if (ack && rd_pend_q)
        begin
            rd_val_d = rdata;
            idle_ok_d = ((rdata & `PSQ_IDLEST_MASK) == 32'h0000_0000);
        end
    end
    always_ff @(posedge clk)
    begin
        step_q <= sys_rst ? 3'h0 : step_d;
        rd_pend_q <= sys_rst ? 1'b0 : rd_pend_d;
        rd_val_q <= sys_rst ? 32'h0000_0000 : rd_val_d;
        idle_ok_q <= sys_rst ? 1'b0 : idle_ok_d;
    end
    // ========
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ack_follow_a: assert property ((wr_en || rd_en) |=> ack)
        else $error("no ack after request");
    single_req_a: assert property ((wr_en || rd_en) |=> !(wr_en || rd_en))
        else $error("request while waiting");
    wake_first_a: assert property ((wr_en && step_q == 3'h0) |->
        (addr == `PSQ_REG_CLKDOM && wdata == `PSQ_CLKDOM_WAKEUP)) else $error("bad step 0");
    clk_on_a: assert property ((wr_en && step_q == 3'h1) |->
        (addr == `PSQ_REG_MODCLK && wdata == `PSQ_MODCLK_ENABLE)) else $error("bad step 1");
    rst_rel_a: assert property ((wr_en && step_q == 3'h2) |->
        (addr == `PSQ_REG_RESET && wdata == `PSQ_RESET_RELEASE)) else $error("bad step 2");
    poll_addr_a: assert property (rd_en |->
        addr == ((step_q == 3'h4) ? `PSQ_REG_PWRST : `PSQ_REG_MODCLK)) else $error("bad read");
    hardware_automatic_transition_a: assert property ((wr_en && step_q == 3'h3) |-> idle_ok_q &&
        addr == `PSQ_REG_CLKDOM && wdata == `PSQ_CLKDOM_HWAUTO) else $error("bad step 3");
    pwr_off_a: assert property ((wr_en && step_q == 3'h4) |->
        addr == `PSQ_REG_PWRST && wdata == (rd_val_q & `PSQ_PWRST_OFF_MASK)) else $error("bad step 4");
    gate_a: assert property ((wr_en && step_q == 3'h5) |->
        (addr == `PSQ_REG_MODCLK && wdata == `PSQ_MODCLK_GATE)) else $error("bad step 5");
    rst_set_a: assert property ((wr_en && step_q == 3'h6) |->
        (addr == `PSQ_REG_RESET && wdata == `PSQ_RESET_ASSERT)) else $error("bad step 6");
    cover property (ack && rd_pend_q && idle_ok_d);
    cover property (wr_en && step_q == 3'h4);
    cover property (wr_en && step_q == 3'h6);
endmodule : psq_link_sva
`default_nettype wire

//--- sim/dsp_priority_flag_init_sequence_tb.sv
/* Bench: sequencer and subsystem joined by the link, random start and abort.
 Assumes the constants header and the package are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dsp_priority_flag_init_sequence_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic flag, functional, busy, done, timed_out;
    logic [15:0] lfsr_q = 16'h7104;
    int fail_count = 0;
    int comparisons = 0;
    int wr_seen = 0;
    psq_if link_if ();
    always #4 clk = ~clk;
    always @(posedge clk) if (link_if.wr_en) wr_seen <= wr_seen + 1;
    psq_dev #(.arbitration_priority_flag_init(1'b1)) u_psq_dev (.clk(clk), .sys_rst(sys_rst),
        .clk_en(1'b1), .bus(link_if), .arbitration_priority_flag(flag), .functional(functional));
    psq_host #(.timeout_cyc(50)) u_psq_host (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .start(start), .bus(link_if), .busy(busy), .done(done), .timed_out(timed_out));
    psq_link_sva u_link_sva (.clk(clk), .sys_rst(sys_rst), .wr_en(link_if.wr_en),
        .rd_en(link_if.rd_en), .addr(link_if.addr), .wdata(link_if.wdata),
        .rdata(link_if.rdata), .ack(link_if.ack));
    // ========
    // Helpers
    function automatic logic [15:0] next_lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : next_lfsr
    function automatic int exp_writes(input int runs);
        return 7 * runs;
    endfunction : exp_writes
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task run_seq;
        int n;
        int w0;
        w0 = wr_seen;
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        n = 0;
        @(negedge clk);
        while (done !== 1'b1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        check(done, 1'b1);
        check(flag, 1'b0);
        check(functional, 1'b1);
        check(timed_out, 1'b0);
        check(wr_seen - w0, exp_writes(1));
    endtask : run_seq
    // ========
    // Tests
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check(flag, 1'b1);
        check(functional, 1'b0);
        repeat (lfsr_q[2:0]) @(posedge clk);
        run_seq();
        $display("test 1 done");
        @(posedge clk) sys_rst <= 1'b1;
        @(posedge clk) sys_rst <= 1'b0;
        @(negedge clk);
        check(flag, 1'b0);
        $display("test 2 done");
        for (int i = 0; i < 6; i++)
        begin
            lfsr_q = next_lfsr(lfsr_q);
            @(posedge clk) start <= 1'b1;
            @(posedge clk) start <= 1'b0;
            repeat (lfsr_q[4:0]) @(posedge clk);
            sys_rst <= 1'b1;
            @(posedge clk) sys_rst <= 1'b0;
            @(negedge clk);
            check(busy, 1'b0);
            check(flag, 1'b0);
            run_seq();
            $display("test 3.%0d done", i);
        end
        end_of_test();
    end
    initial
    begin
        #(8 * 5000);
        fail_count++;
        end_of_test();
    end
endmodule : dsp_priority_flag_init_sequence_tb
`default_nettype wire
